// ### rtl/pfs_seq.sv
// Purpose: fault response and restart sequencer for a buck regulator
// Assumes: soft start and calibration completion arrive as same-clock levels
// Notes:   power good pin is open drain, driven low only
`timescale 1ns/1ps
module pfs_seq
#(
   parameter int HICCUP_CYCLES = pfs_pkg::HICCUP_CYC,
   parameter int SYSRST_CYCLES = pfs_pkg::SYSRST_CYC
) (
   input  wire logic                 clk,            // 100 MHz timebase
   input  wire logic                 rstn,           // async reset, active low
   input  wire logic                 bias_ok,        // bias supply valid (pin)
   input  wire logic                 enable_in,      // turn-on input (pin)
   input  wire logic                 hiccup_strap_n, // strap: high float = hiccup, low = latch-off
   input  wire pfs_pkg::pfs_faults_t faults,         // raw fault detections (pins)
   input  wire logic                 cooled,         // die below low thermal limit
   input  wire logic                 cal_done,       // auto-calibration finished
   input  wire logic                 ss_done,        // soft start finished
   output logic                      power_good_out, // power good pin level to pad
   output logic                      power_good_oe,  // open-drain pull-down enable
   output logic                      switches_on,    // power stage allowed to switch
   output logic                      ramp_start,     // start soft-start ramp
   output pfs_pkg::pfs_state_t       state           // sequencer state
);
   import pfs_pkg::*;

   initial if (HICCUP_CYCLES < 1 || SYSRST_CYCLES < 1) $error("pfs_seq: counts must be positive");

   logic bias_s, en_s, strap_s, cool_s;
   logic oc_q, uv_q, ov_q, tsd_q;
   logic [31:0] timer;
   pfs_state_t  next_state;

   wire supply_ok   = bias_s && en_s;
   wire in_prot     = (state == PFS_SOFTSTART) || (state == PFS_RUN);
   wire in_run      = state == PFS_RUN;
   wire tsd_hit     = tsd_q && supply_ok;
   wire prot_fault  = oc_q || uv_q || ov_q;
   wire hiccup_mode = strap_s;
   wire sysrst_done = timer >= 32'(SYSRST_CYCLES - 1);
   wire hiccup_done = timer >= 32'(HICCUP_CYCLES - 1);

   pfs_qual #(.CNT(1)) u_bias (.clk(clk), .rstn(rstn), .arm(1'b0), .raw(bias_ok),
                               .level(bias_s), .qualified());
   pfs_qual #(.CNT(1)) u_en (.clk(clk), .rstn(rstn), .arm(1'b0), .raw(enable_in),
                             .level(en_s), .qualified());
   pfs_qual #(.CNT(1)) u_strap (.clk(clk), .rstn(rstn), .arm(1'b0), .raw(hiccup_strap_n),
                                .level(strap_s), .qualified());
   pfs_qual #(.CNT(1)) u_cool (.clk(clk), .rstn(rstn), .arm(1'b0), .raw(cooled),
                               .level(cool_s), .qualified());
   pfs_qual #(.CNT(OC_CYC)) u_oc (.clk(clk), .rstn(rstn), .arm(in_prot),
                                  .raw(faults.overcurrent_fault), .level(), .qualified(oc_q));
   pfs_qual #(.CNT(UV_CYC)) u_uv (.clk(clk), .rstn(rstn), .arm(in_run),
                                  .raw(faults.undervoltage_fault), .level(), .qualified(uv_q));
   pfs_qual #(.CNT(OV_CYC)) u_ov (.clk(clk), .rstn(rstn), .arm(in_prot),
                                  .raw(faults.overvoltage_fault), .level(), .qualified(ov_q));
   pfs_qual #(.CNT(1)) u_tsd (.clk(clk), .rstn(rstn), .arm(1'b1), .raw(faults.thermal_trip),
                              .level(), .qualified(tsd_q));

   always_comb
   begin
      next_state = state;
      unique case (state)
         PFS_OFF:       if (supply_ok) next_state = PFS_SYSRST;
         PFS_SYSRST:    if (sysrst_done) next_state = PFS_CAL;
         PFS_CAL:       if (cal_done) next_state = PFS_SOFTSTART;
         PFS_SOFTSTART: if (ss_done) next_state = PFS_RUN;
         PFS_RUN:       ;
         PFS_HICCUP:    if (hiccup_done) next_state = PFS_SYSRST;
         PFS_LATCHED:   ;
         // wait for the trip to clear as well, so a lagging trip cannot re-enter at once
         PFS_THERMAL:   if (cool_s && !tsd_hit) next_state = PFS_SYSRST;
      endcase
      if (in_prot && prot_fault)
         next_state = hiccup_mode ? PFS_HICCUP : PFS_LATCHED;
      if (tsd_hit && state != PFS_THERMAL)
         next_state = PFS_THERMAL;
      if (!supply_ok)
         next_state = PFS_OFF;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state <= PFS_OFF;
      else
         state <= next_state;
   end

   // one shared interval counter, cleared on every state change
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         timer <= 32'h0;
      else if (next_state != state)
         timer <= 32'h0;
      else if (timer != 32'hffffffff)
         timer <= timer + 32'h1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         power_good_out <= 1'b0;
         power_good_oe  <= 1'b1;
         switches_on    <= 1'b0;
         ramp_start     <= 1'b0;
      end
      else
      begin
         power_good_out <= 1'b0;
         power_good_oe  <= next_state != PFS_RUN;
         switches_on    <= next_state == PFS_SOFTSTART || next_state == PFS_RUN;
         ramp_start     <= next_state == PFS_SOFTSTART && state == PFS_CAL;
      end
   end

   sequence s_fault_in_prot;
      in_prot && prot_fault && supply_ok && !tsd_hit;
   endsequence

   sequence s_cal_ready;
      state == PFS_CAL && cal_done && supply_ok && !tsd_hit;
   endsequence

   sequence s_cool_ready;
      state == PFS_THERMAL && cool_s && !tsd_hit && supply_ok;
   endsequence

   sequence s_uv_in_run;
      in_run && uv_q && supply_ok && !tsd_hit;
   endsequence

   sequence s_ov_in_prot;
      in_prot && ov_q && supply_ok && !tsd_hit;
   endsequence

   a_pg_after_ss: assert property (@(posedge clk) disable iff (!rstn)
      $fell(power_good_oe) |-> $past(state) == PFS_SOFTSTART && $past(ss_done))
      else $error("power good released outside run");
   a_pg_fault_low: assert property (@(posedge clk) disable iff (!rstn)
      s_fault_in_prot |=> power_good_oe && !switches_on)
      else $error("power good not pulled on fault");
   a_mode_select: assert property (@(posedge clk) disable iff (!rstn)
      s_fault_in_prot |=> state == ($past(hiccup_mode) ? PFS_HICCUP : PFS_LATCHED))
      else $error("wrong protection response");
   a_hiccup_time: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_HICCUP && timer < 32'(HICCUP_CYCLES - 1) && supply_ok && !tsd_hit
      |=> state == PFS_HICCUP)
      else $error("hiccup idle ended early");
   a_hiccup_restart: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_HICCUP && hiccup_done && supply_ok && !tsd_hit |=> state == PFS_SYSRST)
      else $error("no restart after hiccup");
   a_tsd_gate: assert property (@(posedge clk) disable iff (!rstn)
      tsd_q && supply_ok |=> state == PFS_THERMAL || !$past(supply_ok, 1) || state == PFS_OFF)
      else $error("thermal trip ignored");
   a_tsd_ignore: assert property (@(posedge clk) disable iff (!rstn)
      !supply_ok |=> state == PFS_OFF)
      else $error("state held without valid supply");
   a_sysrst_wait: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_SYSRST && timer < 32'(SYSRST_CYCLES - 1) && supply_ok && !tsd_hit
      |=> state == PFS_SYSRST)
      else $error("ramp before reset period");
   a_latched_hold: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_LATCHED && supply_ok && !tsd_hit |=> state == PFS_LATCHED)
      else $error("latch-off left without toggle");

   a_ramp_single: assert property (@(posedge clk) disable iff (!rstn)
      ramp_start |=> !ramp_start)
      else $error("ramp start longer than one cycle");

   a_ramp_entry: assert property (@(posedge clk) disable iff (!rstn)
      s_cal_ready |=> ramp_start && state == PFS_SOFTSTART)
      else $error("no ramp after calibration");

   a_sysrst_quiet: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_SYSRST |-> !switches_on && power_good_oe)
      else $error("switching during system reset");

   a_uv_switch_off: assert property (@(posedge clk) disable iff (!rstn)
      s_uv_in_run |=> !switches_on && power_good_oe)
      else $error("undervoltage left switches on");

   a_ov_trip: assert property (@(posedge clk) disable iff (!rstn)
      s_ov_in_prot |=> power_good_oe)
      else $error("overvoltage left power good high");

   a_oc_armed: assert property (@(posedge clk) disable iff (!rstn)
      $rose(oc_q) |-> $past(in_prot))
      else $error("overcurrent qualified while disarmed");

   a_thermal_off: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_THERMAL |-> !switches_on && power_good_oe)
      else $error("thermal shutdown left stage on");

   a_thermal_stay: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_THERMAL && !cool_s && supply_ok |=> state == PFS_THERMAL)
      else $error("thermal shutdown left while hot");

   a_thermal_exit: assert property (@(posedge clk) disable iff (!rstn)
      s_cool_ready |=> state == PFS_SYSRST)
      else $error("no restart after cooling");

   a_off_quiet: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_OFF |-> !switches_on && power_good_oe)
      else $error("power good high in shutdown");

   a_hiccup_quiet: assert property (@(posedge clk) disable iff (!rstn)
      state == PFS_HICCUP |-> !switches_on && power_good_oe)
      else $error("power good high during hiccup");

   a_pg_data_low: assert property (@(posedge clk) disable iff (!rstn)
      !power_good_out)
      else $error("open-drain data not low");
endmodule

// ### rtl/pfs_pkg.sv
// Purpose: constants and types for the protection fault sequencer
// Assumes: 100 MHz clock, single clock domain
package pfs_pkg;
   localparam int CLK_MHZ       = 100;
   localparam int HICCUP_US     = 32000;
   localparam int SYSRST_NS     = 700000;
   localparam int OC_PERSIST_NS = 50000;
   localparam int UV_PERSIST_NS = 1000;
   localparam int OV_PERSIST_NS = 1000;
   localparam int HICCUP_CYC    = HICCUP_US * CLK_MHZ;
   localparam int SYSRST_CYC    = SYSRST_NS * CLK_MHZ / 1000;
   localparam int OC_CYC        = OC_PERSIST_NS * CLK_MHZ / 1000;
   localparam int UV_CYC        = UV_PERSIST_NS * CLK_MHZ / 1000;
   localparam int OV_CYC        = OV_PERSIST_NS * CLK_MHZ / 1000;
   localparam int SYNC_STAGES   = 3;

   typedef enum logic [2:0] {
      PFS_OFF,
      PFS_SYSRST,
      PFS_CAL,
      PFS_SOFTSTART,
      PFS_RUN,
      PFS_HICCUP,
      PFS_LATCHED,
      PFS_THERMAL
   } pfs_state_t;

   typedef struct packed {
      logic overcurrent_fault;
      logic undervoltage_fault;
      logic overvoltage_fault;
      logic thermal_trip;
   } pfs_faults_t;
endpackage

// ### rtl/pfs_qual.sv
// Purpose: three-stage pin synchroniser with persistence qualifier
// Assumes: raw input is asynchronous to clk
// Notes:   qualified output rises once the level held longer than count cycles
`timescale 1ns/1ps
module pfs_qual #(
   parameter int CNT = 100
) (
   input  wire logic clk,        // system clock
   input  wire logic rstn,       // async reset, active low
   input  wire logic arm,        // detection window open
   input  wire logic raw,        // asynchronous fault level
   output logic      level,      // synchronised level
   output logic      qualified   // fault persisted beyond CNT cycles
);
   initial if (CNT < 1) $error("pfs_qual: CNT must be at least 1");

   logic [2:0]             sync;
   logic [$clog2(CNT+1):0] cnt;
   logic                   agreed;

   // stage 0 is read only by stage 1
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sync <= 3'h0;
      else
         sync <= {sync[1:0], raw};
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         agreed <= 1'b0;
      else if (sync[1] == sync[2])
         agreed <= sync[2];
   end
   assign level = agreed;

   // counting strictly more than CNT cycles of continuous presence
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt <= '0;
      else if (!agreed || !arm)
         cnt <= '0;
      else if (cnt <= ($clog2(CNT+1)+1)'(CNT))
         cnt <= cnt + 1'b1;
   end
   assign qualified = cnt > ($clog2(CNT+1)+1)'(CNT);
endmodule

// ### tb/pfs_ctrl.sv
// Purpose: far-side model: controller answers calibration and soft start, pull-up on power good
// Assumes: state and oe come from the sequencer on the same clock
// Notes:   answers are driven on the falling edge, after lag cycles in the phase
`timescale 1ns/1ps
module pfs_ctrl
   import pfs_pkg::*;
(
   input  wire logic       clk,           // system clock
   input  wire pfs_state_t state,         // sequencer state
   input  wire logic       power_good_oe, // pull-down enable
   input  wire logic [3:0] lag,           // answer delay in cycles
   output logic            cal_done,      // calibration finished
   output logic            ss_done,       // soft start finished
   output logic            pg_wire        // resolved power good level
);
   pfs_state_t seen;
   int         cnt;
   // external pull-up: pin only reads high while nobody pulls low
   assign pg_wire = power_good_oe ? 1'b0 : 1'b1;
   initial
   begin
      cal_done = 1'b0;
      ss_done  = 1'b0;
      cnt      = 0;
   end
   always @(negedge clk)
   begin
      cnt      = (state == seen) ? cnt + 1 : 0;
      seen     = state;
      // level held only inside its own phase, so a late answer never leaks forward
      cal_done <= (state == PFS_CAL) && (cnt >= lag);
      ss_done  <= (state == PFS_SOFTSTART) && (cnt >= lag);
   end
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for the protection fault sequencer
// Assumes: shortened hiccup and system reset counts
// Notes:   every state change is matched against the oldest expected note
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
   import pfs_pkg::*;
   localparam int HC = 200;
   localparam int SC = 50;
   logic        clk = 1'b0, rstn = 1'b0, bias_ok = 1'b0, enable_in = 1'b0;
   logic        strap_n = 1'b1, cooled = 1'b1;
   pfs_faults_t faults = '0;
   logic [3:0]  lag = 4'h3;
   logic [15:0] seed = 16'h0056;
   logic        cal_done, ss_done, pg_wire, pg_out, pg_oe, sw_on, ramp;
   pfs_state_t  state, e, last = PFS_OFF;
   pfs_state_t  exp_q[$];
   int          n_errors = 0, n_compared = 0, dwell = 0;
   pfs_seq #(.HICCUP_CYCLES(HC), .SYSRST_CYCLES(SC)) uut (.clk(clk), .rstn(rstn), .bias_ok(bias_ok),
      .enable_in(enable_in), .hiccup_strap_n(strap_n), .faults(faults), .cooled(cooled),
      .cal_done(cal_done), .ss_done(ss_done), .power_good_out(pg_out), .power_good_oe(pg_oe),
      .switches_on(sw_on), .ramp_start(ramp), .state(state));
   pfs_ctrl u_ctrl (.clk(clk), .state(state), .power_good_oe(pg_oe), .lag(lag),
      .cal_done(cal_done), .ss_done(ss_done), .pg_wire(pg_wire));
   initial
   begin
      forever #5 clk = ~clk;
   end
   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed;
   endfunction
   task automatic up_seq();
      lag = 4'(xs() | 16'h0003);
      exp_q.push_back(PFS_SYSRST);
      exp_q.push_back(PFS_CAL);
      exp_q.push_back(PFS_SOFTSTART);
      exp_q.push_back(PFS_RUN);
   endtask
   task automatic wait_st(input pfs_state_t s);
      for (int i = 0; i < 20000 && state !== s; i++) @(negedge clk);
      `CHK(state, s)
   endtask
   task automatic settle(input string name, input logic pg);
      repeat (3) @(negedge clk);
      `CHK(pg_wire, pg)
      `CHK(pg_out, 1'b0)
      $display("test %0s done", name);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watcher: any change not noted in advance pops nothing and mismatches
   always @(negedge clk)
   begin
      if (rstn && state !== last)
      begin
         if (last == PFS_SYSRST) `CHK(dwell >= SC && dwell <= SC + 1, 1'b1)
         if (last == PFS_HICCUP) `CHK(dwell >= HC && dwell <= HC + 1, 1'b1)
         if (state == PFS_CAL) `CHK(pg_wire, 1'b0)
         `CHK(ramp, state == PFS_SOFTSTART)
         `CHK(sw_on, state == PFS_SOFTSTART || state == PFS_RUN)
         e = (exp_q.size() > 0) ? exp_q.pop_front() : last;
         `CHK(state, e)
         dwell = 0;
      end
      dwell++;
      last = state;
   end
   initial
   begin
      #(60000 * 10);
      n_errors++;
      end_of_test();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      up_seq();
      bias_ok   = 1'b1;
      enable_in = 1'b1;
      wait_st(PFS_RUN);
      settle("power_up", 1'b1);
      exp_q.push_back(PFS_HICCUP);
      up_seq();
      faults.overvoltage_fault = 1'b1;
      wait_st(PFS_HICCUP);
      faults.overvoltage_fault = 1'b0;
      settle("ov_hiccup_pg", 1'b0);
      wait_st(PFS_RUN);
      strap_n = 1'b0;
      faults.undervoltage_fault = 1'b1;
      repeat (10 + xs() % 60) @(negedge clk);
      faults.undervoltage_fault = 1'b0;
      repeat (30) @(negedge clk);
      exp_q.push_back(PFS_LATCHED);
      faults.undervoltage_fault = 1'b1;
      wait_st(PFS_LATCHED);
      faults.undervoltage_fault = 1'b0;
      `CHK(sw_on, 1'b0)
      repeat (300) @(negedge clk);
      exp_q.push_back(PFS_OFF);
      up_seq();
      enable_in = 1'b0;
      repeat (10) @(negedge clk);
      enable_in = 1'b1;
      wait_st(PFS_RUN);
      settle("uv_latch_restart", 1'b1);
      strap_n = 1'b1;
      exp_q.push_back(PFS_HICCUP);
      up_seq();
      faults.overcurrent_fault = 1'b1;
      wait_st(PFS_HICCUP);
      faults.overcurrent_fault = 1'b0;
      wait_st(PFS_RUN);
      settle("oc_hiccup", 1'b1);
      exp_q.push_back(PFS_THERMAL);
      faults.thermal_trip = 1'b1;
      cooled = 1'b0;
      wait_st(PFS_THERMAL);
      `CHK(sw_on, 1'b0)
      up_seq();
      faults.thermal_trip = 1'b0;
      cooled = 1'b1;
      wait_st(PFS_RUN);
      settle("thermal", 1'b1);
      exp_q.push_back(PFS_OFF);
      enable_in = 1'b0;
      faults.thermal_trip = 1'b1;
      repeat (40) @(negedge clk);
      `CHK(state, PFS_OFF)
      settle("thermal_ignored", 1'b0);
      end_of_test();
   end
endmodule
